//--- rtl/cip_input_path_ctrl.sv
// Register bank and routing decode for the codec analog input path
`timescale 1ns/1ps

// Behaviour
// - Power bits 7 and 6 power down left and right inputs; default 1.
// - Left select 00 input one, 01 input two, 10 reserved, 11 differential.
// - Right select 00 input one, 01 input two, 10 reserved, 11 differential.
// - Differential select bit 7: 0 first pair, 1 second pair.
// - Both differential with all pair bits zero routes first pair to both.
// - Per-channel bit set: right uses its own pair bit 2.
// - Preamp gain runs from 0 to 24 dB in 3 dB steps.
// - Mono field 00 stereo, 01 mix to left, 10 mix to right ADC.
// - Tri bit releases serial output and turns frame and bit clocks into inputs.
// - Slot field places left or right ADC data, or swaps them.
// - Bypass fields choose the input routed straight to the outputs.
// - Bypass codes 000 input one, 001 input two, 011 after preamp.
module cip_input_path_ctrl
(
    input  wire logic                           sys_clk,                // Clock
    input  wire logic                           rst,                    // Sync reset
    input  wire logic [7:0]                     reg_addr,               // Register address
    input  wire logic [7:0]                     reg_wdata,              // Write data
    input  wire logic                           reg_wr,                 // Write strobe
    input  wire logic                           reg_rd,                 // Read strobe
    output logic      [7:0]                     reg_rdata,              // Read data
    output logic                                left_input_power_down,  // Left input off
    output logic                                right_input_power_down, // Right input off
    output cip_pkg::cip_src_e                   left_source,            // Left source
    output cip_pkg::cip_src_e                   right_source,           // Right source
    output logic      [3:0]                     left_preamp_gain,       // Left gain code
    output logic      [3:0]                     right_preamp_gain,      // Right gain code
    output logic      [4:0]                     left_gain_db,           // Left gain dB
    output logic      [4:0]                     right_gain_db,          // Right gain dB
    output logic                                mono_to_left_adc,       // Mix into left
    output logic                                mono_to_right_adc,      // Mix into right
    input  wire logic [cip_pkg::CIP_SAMPLE_W-1:0] left_adc_sample,      // Left ADC word
    input  wire logic [cip_pkg::CIP_SAMPLE_W-1:0] right_adc_sample,     // Right ADC word
    output logic      [cip_pkg::CIP_SAMPLE_W-1:0] left_slot_data,       // Left slot word
    output logic      [cip_pkg::CIP_SAMPLE_W-1:0] right_slot_data,      // Right slot word
    input  wire logic                           adc_serial_bit,         // Serializer bit
    output logic                                adc_serial_out,         // Serial pin out
    output logic                                adc_serial_out_oe_n,    // Pin enable, low
    output logic                                frame_clocks_are_inputs,// Clock direction
    output logic      [2:0]                     left_bypass_source,     // Left bypass
    output logic      [2:0]                     right_bypass_source,    // Right bypass
    output logic                                route_reserved          // Reserved code seen
);
    import cip_pkg::*;

    // ========================================================
    // State
    typedef struct packed {
        logic [7:0]              adc_power;
        logic [7:0]              preamp_gain;
        logic [7:0]              input_select;
        logic [7:0]              diff_mix;
        logic [7:0]              data_format;
        logic [7:0]              bypass_sel;
        logic [7:0]              rdata;
        cip_src_e                left_src;
        cip_src_e                right_src;
        logic [4:0]              gain_db_l;
        logic [4:0]              gain_db_r;
        logic                    mono_l;
        logic                    mono_r;
        logic [CIP_SAMPLE_W-1:0] slot_l;
        logic [CIP_SAMPLE_W-1:0] slot_r;
        logic                    ser_out;
        logic [7:0]              status;
    } cip_state_s;

    cip_state_s st;
    cip_state_s next_st;

    // Source decode from select field and pair bit
    function automatic cip_src_e src_decode(input logic [1:0] sel, input logic pair);
        cip_src_e s;
        s = CIP_SRC_RSVD;
        unique case (sel)
            CIP_SEL_IN1:  s = CIP_SRC_IN1;
            CIP_SEL_IN2:  s = CIP_SRC_IN2;
            CIP_SEL_DIFF: s = pair ? CIP_SRC_DIFF2 : CIP_SRC_DIFF1;
            default:      s = CIP_SRC_RSVD;
        endcase
        return s;
    endfunction

    // Gain code to dB, clamped at top step
    function automatic logic [4:0] gain_decode(input logic [3:0] code);
        logic [4:0] g;
        g = CIP_GAIN_MAX_DB;
        if (code <= CIP_GAIN_MAX_CODE)
        begin
            g = 5'({1'b0, code} * CIP_GAIN_STEP_DB);
        end
        return g;
    endfunction

    logic [1:0] lsel;
    logic [1:0] rsel;
    logic       lpair;
    logic       rpair;

    // ========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        lsel    = 2'h0;
        rsel    = 2'h0;
        lpair   = 1'b0;
        rpair   = 1'b0;
        next_st.rdata = 8'h00;
        // Register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                CIP_ADC_POWER:    next_st.adc_power    = reg_wdata;
                CIP_PREAMP_GAIN:  next_st.preamp_gain  = reg_wdata;
                CIP_INPUT_SELECT: next_st.input_select = reg_wdata;
                CIP_DIFF_MIX:     next_st.diff_mix     = reg_wdata;
                CIP_DATA_FORMAT:  next_st.data_format  = reg_wdata;
                CIP_BYPASS_SEL:   next_st.bypass_sel   = reg_wdata;
                default:          next_st.rdata        = 8'h00;
            endcase
        end
        // Register reads, data stand one cycle
        if (reg_rd)
        begin
            unique case (reg_addr)
                CIP_ADC_POWER:    next_st.rdata = st.adc_power;
                CIP_PREAMP_GAIN:  next_st.rdata = st.preamp_gain;
                CIP_INPUT_SELECT: next_st.rdata = st.input_select;
                CIP_DIFF_MIX:     next_st.rdata = st.diff_mix;
                CIP_DATA_FORMAT:  next_st.rdata = st.data_format;
                CIP_BYPASS_SEL:   next_st.rdata = st.bypass_sel;
                CIP_STATUS:       next_st.rdata = st.status;
                default:          next_st.rdata = 8'h00;
            endcase
        end

        lsel  = next_st.input_select[CIP_LSEL_LSB+:2];
        lpair = next_st.diff_mix[CIP_PAIR_BIT];
        next_st.left_src = src_decode(lsel, lpair);
        rsel  = next_st.input_select[CIP_RSEL_LSB+:2];
        rpair = next_st.input_select[CIP_PER_CH_BIT] ?
                next_st.input_select[CIP_RPAIR_BIT] : next_st.diff_mix[CIP_PAIR_BIT];
        next_st.right_src = src_decode(rsel, rpair);

        next_st.gain_db_l = gain_decode(next_st.preamp_gain[CIP_LGAIN_LSB+:4]);
        next_st.gain_db_r = gain_decode(next_st.preamp_gain[CIP_RGAIN_LSB+:4]);

        next_st.mono_l = (next_st.diff_mix[CIP_MONO_LSB+:2] == CIP_MONO_LEFT);
        next_st.mono_r = (next_st.diff_mix[CIP_MONO_LSB+:2] == CIP_MONO_RIGHT);

        unique case (st.data_format[CIP_SLOT_LSB+:2])
            CIP_SLOT_RIGHT:
            begin
                next_st.slot_l = right_adc_sample;
                next_st.slot_r = right_adc_sample;
            end
            CIP_SLOT_SWAP:
            begin
                next_st.slot_l = right_adc_sample;
                next_st.slot_r = left_adc_sample;
            end
            default:
            begin
                next_st.slot_l = left_adc_sample;
                next_st.slot_r = left_adc_sample;
            end
        endcase

        next_st.ser_out = next_st.diff_mix[CIP_TRI_BIT] ? 1'b0 : adc_serial_bit;

        next_st.status = {
            lpair,
            rpair,
            (next_st.bypass_sel[CIP_RBYP_LSB+:3] == CIP_BYP_RSVD) ||
                (next_st.bypass_sel[CIP_RBYP_LSB+:3] > CIP_BYP_MAX),
            (next_st.bypass_sel[CIP_LBYP_LSB+:3] == CIP_BYP_RSVD) ||
                (next_st.bypass_sel[CIP_LBYP_LSB+:3] > CIP_BYP_MAX),
            (next_st.diff_mix[CIP_MONO_LSB+:2] == 2'h3),
            (next_st.right_src == CIP_SRC_RSVD),
            (next_st.left_src == CIP_SRC_RSVD),
            1'b0
        };

        // Reset values
        if (rst)
        begin
            next_st              = '0;
            next_st.adc_power    = CIP_ADC_POWER_RST;
            next_st.preamp_gain  = CIP_PREAMP_GAIN_RST;
            next_st.input_select = CIP_INPUT_SELECT_RST;
            next_st.diff_mix     = CIP_DIFF_MIX_RST;
            next_st.data_format  = CIP_DATA_FORMAT_RST;
            next_st.bypass_sel   = CIP_BYPASS_SEL_RST;
            next_st.left_src     = CIP_SRC_IN1;
            next_st.right_src    = CIP_SRC_IN1;
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        st <= next_st;
    end

    // ========================================================
    // Outputs
    assign reg_rdata = st.rdata;
    assign left_input_power_down  = st.adc_power[CIP_PDN_LEFT_BIT];
    assign right_input_power_down = st.adc_power[CIP_PDN_RIGHT_BIT];
    assign left_source       = st.left_src;
    assign right_source      = st.right_src;
    assign left_preamp_gain  = st.preamp_gain[CIP_LGAIN_LSB+:4];
    assign right_preamp_gain = st.preamp_gain[CIP_RGAIN_LSB+:4];
    assign left_gain_db      = st.gain_db_l;
    assign right_gain_db     = st.gain_db_r;
    assign mono_to_left_adc  = st.mono_l;
    assign mono_to_right_adc = st.mono_r;
    assign left_slot_data    = st.slot_l;
    assign right_slot_data   = st.slot_r;
    assign adc_serial_out          = st.ser_out;
    assign adc_serial_out_oe_n     = st.diff_mix[CIP_TRI_BIT];
    assign frame_clocks_are_inputs = st.diff_mix[CIP_TRI_BIT];
    assign left_bypass_source  = st.bypass_sel[CIP_LBYP_LSB+:3];
    assign right_bypass_source = st.bypass_sel[CIP_RBYP_LSB+:3];
    assign route_reserved      = |st.status[5:1];

    // ========================================================
    // Assertions
    AST_POWER_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_ADC_POWER |=>
            left_input_power_down == $past(reg_wdata[7]) &&
            right_input_power_down == $past(reg_wdata[6]))
        else $error("input power bits do not follow write");

    AST_LEFT_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_INPUT_SELECT && reg_wdata[7:6] == 2'h1 |=>
            left_source == CIP_SRC_IN2)
        else $error("left select 01 not input two");

    AST_RIGHT_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_INPUT_SELECT && reg_wdata[5:4] == 2'h0 |=>
            right_source == CIP_SRC_IN1)
        else $error("right select 00 not input one");

    AST_LEFT_PAIR: assert property (@(posedge sys_clk) disable iff (rst)
        st.input_select[7:6] == 2'h3 |->
            left_source == (st.diff_mix[7] ? CIP_SRC_DIFF2 : CIP_SRC_DIFF1))
        else $error("left differential pair wrong");

    AST_SHARED_PAIR: assert property (@(posedge sys_clk) disable iff (rst)
        st.input_select[7:4] == 4'hf && st.input_select[3:2] == 2'h0 &&
            !st.diff_mix[7] |-> left_source == CIP_SRC_DIFF1 &&
            right_source == CIP_SRC_DIFF1)
        else $error("shared first pair not on both channels");

    AST_RIGHT_PAIR: assert property (@(posedge sys_clk) disable iff (rst)
        st.input_select[5:4] == 2'h3 && st.input_select[3] |->
            right_source == (st.input_select[2] ? CIP_SRC_DIFF2 : CIP_SRC_DIFF1))
        else $error("right own pair bit ignored");

    AST_GAIN_DB: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_PREAMP_GAIN && reg_wdata[7:4] <= 4'h8 |=>
            left_gain_db == 5'($past(reg_wdata[7:4]) * 3))
        else $error("left gain dB wrong");

    AST_MONO: assert property (@(posedge sys_clk) disable iff (rst)
        mono_to_left_adc == (st.diff_mix[4:3] == 2'h1) &&
            mono_to_right_adc == (st.diff_mix[4:3] == 2'h2))
        else $error("mono routing wrong");

    AST_TRI: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_DIFF_MIX && reg_wdata[2] |=>
            adc_serial_out_oe_n && frame_clocks_are_inputs && !adc_serial_out)
        else $error("tri state not taken");

    AST_SWAP: assert property (@(posedge sys_clk) disable iff (rst)
        st.data_format[7:6] == 2'h3 && !reg_wr |=>
            right_slot_data == $past(left_adc_sample) &&
            left_slot_data == $past(right_adc_sample))
        else $error("slot swap wrong");

    AST_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_BYPASS_SEL |=>
            left_bypass_source == $past(reg_wdata[5:3]) &&
            right_bypass_source == $past(reg_wdata[2:0]))
        else $error("bypass fields not written");

    AST_READ_ONCE: assert property (@(posedge sys_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

    AST_RIGHT_GAIN: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_PREAMP_GAIN && reg_wdata[3:0] <= 4'h8 |=>
            right_gain_db == 5'($past(reg_wdata[3:0]) * 3))
        else $error("right gain dB wrong");

    AST_GAIN_CLAMP: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_PREAMP_GAIN && reg_wdata[7:4] > 4'h8 |=>
            left_gain_db == 5'h18)
        else $error("left gain above top step not clamped");

    AST_LEFT_IN1: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_INPUT_SELECT && reg_wdata[7:6] == 2'h0 |=>
            left_source == CIP_SRC_IN1)
        else $error("left select 00 not input one");

    AST_RIGHT_IN2: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_INPUT_SELECT && reg_wdata[5:4] == 2'h1 |=>
            right_source == CIP_SRC_IN2)
        else $error("right select 01 not input two");

    AST_TRI_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == CIP_DIFF_MIX && !reg_wdata[2] |=>
            !adc_serial_out_oe_n && !frame_clocks_are_inputs)
        else $error("serial output not driven with tri bit clear");

    AST_READ_DATA: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == CIP_DIFF_MIX |=> reg_rdata == $past(st.diff_mix))
        else $error("read data not the register value");

    AST_ROUTE_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
        !route_reserved |-> st.input_select[7:6] != 2'h2 &&
            st.input_select[5:4] != 2'h2 && st.diff_mix[4:3] != 2'h3)
        else $error("reserved route code not flagged");

endmodule // cip_input_path_ctrl

//--- common/cip_pkg.sv
// Constants shared by the codec input path control block
package cip_pkg;

    // ========================================================
    // Register offsets
    localparam logic [7:0] CIP_ADC_POWER    = 8'h03;
    localparam logic [7:0] CIP_PREAMP_GAIN  = 8'h09;
    localparam logic [7:0] CIP_INPUT_SELECT = 8'h0a;
    localparam logic [7:0] CIP_DIFF_MIX     = 8'h0b;
    localparam logic [7:0] CIP_DATA_FORMAT  = 8'h0c;
    localparam logic [7:0] CIP_BYPASS_SEL   = 8'h26;
    localparam logic [7:0] CIP_STATUS       = 8'h3f;

    // ========================================================
    // Reset values
    localparam logic [7:0] CIP_ADC_POWER_RST    = 8'hfc;
    localparam logic [7:0] CIP_PREAMP_GAIN_RST  = 8'h00;
    localparam logic [7:0] CIP_INPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] CIP_DIFF_MIX_RST     = 8'h06;
    localparam logic [7:0] CIP_DATA_FORMAT_RST  = 8'h00;
    localparam logic [7:0] CIP_BYPASS_SEL_RST   = 8'h00;

    // ========================================================
    // Field positions
    localparam int CIP_PDN_LEFT_BIT  = 7;
    localparam int CIP_PDN_RIGHT_BIT = 6;
    localparam int CIP_LSEL_LSB      = 6;
    localparam int CIP_RSEL_LSB      = 4;
    localparam int CIP_PER_CH_BIT    = 3;
    localparam int CIP_RPAIR_BIT     = 2;
    localparam int CIP_PAIR_BIT      = 7;
    localparam int CIP_MONO_LSB      = 3;
    localparam int CIP_TRI_BIT       = 2;
    localparam int CIP_SLOT_LSB      = 6;
    localparam int CIP_LGAIN_LSB     = 4;
    localparam int CIP_RGAIN_LSB     = 0;
    localparam int CIP_LBYP_LSB      = 3;
    localparam int CIP_RBYP_LSB      = 0;

    // ========================================================
    // Field codes and gain figures
    localparam logic [1:0] CIP_SEL_IN1    = 2'h0;
    localparam logic [1:0] CIP_SEL_IN2    = 2'h1;
    localparam logic [1:0] CIP_SEL_DIFF   = 2'h3;
    localparam logic [1:0] CIP_MONO_LEFT  = 2'h1;
    localparam logic [1:0] CIP_MONO_RIGHT = 2'h2;
    localparam logic [1:0] CIP_SLOT_RIGHT = 2'h2;
    localparam logic [1:0] CIP_SLOT_SWAP  = 2'h3;
    localparam logic [2:0] CIP_BYP_RSVD   = 3'h2;
    localparam logic [2:0] CIP_BYP_MAX    = 3'h3;
    localparam logic [3:0] CIP_GAIN_MAX_CODE = 4'h8;
    localparam logic [4:0] CIP_GAIN_STEP_DB  = 5'h03;
    localparam logic [4:0] CIP_GAIN_MAX_DB   = 5'h18;
    localparam int         CIP_SAMPLE_W      = 24;

    // Effective channel source
    typedef enum logic [2:0] {
        CIP_SRC_IN1,
        CIP_SRC_IN2,
        CIP_SRC_DIFF1,
        CIP_SRC_DIFF2,
        CIP_SRC_RSVD
    } cip_src_e;

endpackage

//--- dv/cip_host_model.sv
// Host controller model that drives the register control port
`timescale 1ns/1ps

module cip_host_model
(
    input  wire logic       sys_clk,   // Clock
    output logic      [7:0] reg_addr,  // Register address
    output logic      [7:0] reg_wdata, // Write data
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    input  wire logic [7:0] reg_rdata  // Read data
);
    // ========================================================
    // Idle levels at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ========================================================
    // Bus cycles; released lines show the inverse of the last value
    // callers pass no reserved codes
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // cip_host_model

//--- dv/cip_input_path_ctrl_tb.sv
// Self-checking testbench for the codec input path control block
`timescale 1ns/1ps

module cip_input_path_ctrl_tb;
    import cip_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, lpd, rpd, m_l, m_r, ser_out, oe_n, clk_in, rsvd;
    cip_src_e    l_src, r_src;
    logic [3:0]  l_gain, r_gain;
    logic [4:0]  l_db, r_db;
    logic [23:0] l_smp = 24'h000000;
    logic [23:0] r_smp = 24'h000000;
    logic [23:0] l_slot, r_slot;
    logic [2:0]  l_byp, r_byp;
    logic        ser_bit = 1'b0;
    logic [7:0]  rd;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cycles = 0;

    // Clock at 40 MHz
    always #12.5 sys_clk = ~sys_clk;

    cip_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    cip_input_path_ctrl dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .left_input_power_down(lpd), .right_input_power_down(rpd), .left_source(l_src),
        .right_source(r_src), .left_preamp_gain(l_gain), .right_preamp_gain(r_gain),
        .left_gain_db(l_db), .right_gain_db(r_db), .mono_to_left_adc(m_l),
        .mono_to_right_adc(m_r), .left_adc_sample(l_smp), .right_adc_sample(r_smp),
        .left_slot_data(l_slot), .right_slot_data(r_slot), .adc_serial_bit(ser_bit),
        .adc_serial_out(ser_out), .adc_serial_out_oe_n(oe_n),
        .frame_clocks_are_inputs(clk_in), .left_bypass_source(l_byp),
        .right_bypass_source(r_byp), .route_reserved(rsvd));

    // ========================================================
    // Verdict, comparison and hang guard
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // ========================================================
    // Scenarios
    task automatic t_reset();
        host.rd_reg(CIP_INPUT_SELECT, rd);
        check(rd, 8'h00);
        @(posedge sys_clk);
        #1;
        check(reg_rdata, 8'h00);
        host.rd_reg(CIP_DIFF_MIX, rd);
        check(rd, 8'h06);
        host.rd_reg(CIP_DATA_FORMAT, rd);
        check(rd, 8'h00);
        host.rd_reg(CIP_ADC_POWER, rd);
        check(rd, 8'hfc);
        check({lpd, rpd}, 2'b11);
        check({l_src, r_src}, {CIP_SRC_IN1, CIP_SRC_IN1});
        check({l_byp, r_byp, m_l, m_r}, 8'h00);
        check(rsvd, 1'b0);
        host.rd_reg(8'h55, rd);
        check(rd, 8'h00);
    endtask

    task automatic t_power();
        host.wr_reg(CIP_ADC_POWER, 8'h3c);
        check({lpd, rpd}, 2'b00);
        host.wr_reg(CIP_ADC_POWER, 8'hbc);
        check({lpd, rpd}, 2'b10);
        host.wr_reg(CIP_ADC_POWER, 8'h7c);
        check({lpd, rpd}, 2'b01);
    endtask

    task automatic t_select();
        logic [7:0] sv [9] = '{8'h00, 8'h50, 8'h40, 8'h30, 8'hf0, 8'hf0, 8'hfc, 8'hf8, 8'hf4};
        logic [7:0] dv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
        cip_src_e   le [9] = '{CIP_SRC_IN1, CIP_SRC_IN2, CIP_SRC_IN2, CIP_SRC_IN1, CIP_SRC_DIFF1,
                               CIP_SRC_DIFF2, CIP_SRC_DIFF1, CIP_SRC_DIFF2, CIP_SRC_DIFF1};
        cip_src_e   re [9] = '{CIP_SRC_IN1, CIP_SRC_IN2, CIP_SRC_IN1, CIP_SRC_DIFF1, CIP_SRC_DIFF1,
                               CIP_SRC_DIFF2, CIP_SRC_DIFF2, CIP_SRC_DIFF1, CIP_SRC_DIFF1};
        for (int i = 0; i < 9; i++)
        begin
            host.wr_reg(CIP_DIFF_MIX, dv[i]);
            host.wr_reg(CIP_INPUT_SELECT, sv[i]);
            check(l_src, le[i]);
            check(r_src, re[i]);
        end
        host.rd_reg(CIP_INPUT_SELECT, rd);
        check(rd, 8'hf4);
        host.wr_reg(CIP_DIFF_MIX, 8'h80);
        host.rd_reg(CIP_STATUS, rd);
        check(rd, 8'hc0);
        check(rsvd, 1'b0);
    endtask

    task automatic t_gain();
        for (int c = 0; c <= 8; c++)
        begin
            host.wr_reg(CIP_PREAMP_GAIN, {4'(c), 4'(8 - c)});
            check({l_gain, r_gain}, {4'(c), 4'(8 - c)});
            check({l_db, r_db}, {5'(3 * c), 5'(3 * (8 - c))});
        end
        host.wr_reg(CIP_PREAMP_GAIN, 8'h9f);
        check({l_db, r_db}, {5'h18, 5'h18});
    endtask

    task automatic t_mono_tri();
        for (int c = 0; c < 3; c++)
        begin
            host.wr_reg(CIP_DIFF_MIX, {3'h0, 2'(c), 3'h0});
            check({m_l, m_r}, {c == 1, c == 2});
        end
        check({oe_n, clk_in}, 2'b00);
        @(posedge sys_clk);
        ser_bit <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(ser_out, 1'b1);
        host.wr_reg(CIP_DIFF_MIX, 8'h04);
        #25;
        check({oe_n, clk_in, ser_out}, 3'b110);
    endtask

    task automatic t_slot();
        logic [47:0] ex [4];
        ex = '{{l_smp, l_smp}, {l_smp, l_smp}, {r_smp, r_smp}, {r_smp, l_smp}};
        for (int c = 0; c < 4; c++)
        begin
            host.wr_reg(CIP_DATA_FORMAT, {2'(c), 6'h00});
            @(posedge sys_clk);
            #1;
            check({l_slot, r_slot}, ex[c]);
        end
    endtask

    task automatic t_bypass();
        logic [2:0] cd [3] = '{3'h0, 3'h1, 3'h3};
        for (int i = 0; i < 3; i++)
        begin
            host.wr_reg(CIP_BYPASS_SEL, {2'h0, cd[i], cd[2 - i]});
            check({l_byp, r_byp}, {cd[i], cd[2 - i]});
        end
    endtask

    // ========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst   <= 1'b0;
        l_smp <= 24'h123456;
        r_smp <= 24'habcdef;
        t_reset();
        t_power();
        t_select();
        t_gain();
        t_mono_tri();
        t_slot();
        t_bypass();
        complete_run();
    end
endmodule // cip_input_path_ctrl_tb
